// [core/spba_adapter.sv]
// Slow peripheral bus adapter: qualifies the chip select with the address
// strobe, picks the serial port or timer by address bit A3, holds off the
// command strobes, and drives the data transceiver enable and direction.
// Assumes the processor's wait-state generator sets the cycle length and
// that its region holds the peripherals as 8-bit, non-burst, non-pipelined.
//
// Contract
// RULE1: Address bit A3 selects serial port or timer.
// RULE2: Chip select counts only with address strobe.
// RULE3: Machine makes enables, strobes and data enable.
// RULE4: Transceiver enable is OR of low-true selects.
// RULE5: Transceiver direction follows processor direction directly.
// RULE6: Write strobe follows wait while writing.
// RULE7: Strobes delayed to meet command recovery time.
// RULE8: Peripheral region is 8-bit, non-burst, non-pipelined.
// RULE9: Processor wait-state generator sets cycle length.
// RULE10: Processor leaves data undriven during turnaround states.
// RULE11: Turnaround states cover peripheral data float time.
// RULE12: Three hold-off states with chip enable, no strobes.
// RULE13: Read strobe held until burst last, then idle.
// RULE14: Write strobe from wait until burst last.
// RULE15: Reset gives idle with all outputs deasserted.
`timescale 1ns/1ps
module spba_adapter
  import spba_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Processor local bus
  input wire logic address_strobe_n_i,
  input wire logic burst_last_n_i,
  input wire logic wait_n_i,
  input wire logic transfer_direction_i,
  input wire logic addr_bit3_i,
  // Address-only chip select from the decoder
  input wire logic chip_select_n_i,
  // Peripheral strobes
  output logic serial_chip_enable_n_o,
  output logic timer_chip_enable_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic data_enable_n_o,
  // Data transceiver control
  output logic transceiver_enable_n_o,
  output logic transceiver_dir_o
);

  localparam logic [SPBA_SYNC_W-1:0] SYNC_RST = 5'h1b;

  logic [SPBA_SYNC_W-1:0] pins;
  logic [SPBA_SYNC_W-1:0] synced;
  spba_state_t state_q, state_d;
  spba_strobes_t strobes_q, strobes_d;
  logic sel_serial_q, sel_serial_d;
  logic is_write_q, is_write_d;
  logic xcvr_en_n_q, xcvr_en_n_d;
  logic xcvr_dir_q, xcvr_dir_d;

  always_comb begin
    pins = '0;
    pins[SPBA_IX_ADDR_STROBE] = address_strobe_n_i;
    pins[SPBA_IX_CS] = chip_select_n_i;
    pins[SPBA_IX_A3] = addr_bit3_i;
    pins[SPBA_IX_WAIT] = wait_n_i;
    pins[SPBA_IX_BURST_LAST] = burst_last_n_i;
  end

  // The pins arrive from outside, so each but the transfer direction passes two flops before use; the
  // cost is two cycles of latency that the wait-state count must absorb.
  spba_sync #(
    .WIDTH(SPBA_SYNC_W),
    .RESET_VAL(SYNC_RST)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pins),
    .sync_o(synced)
  );

  logic addr_strobe_n_s, cs_n_s, a3_s, wait_n_s, burst_last_n_s, selected;
  assign addr_strobe_n_s = synced[SPBA_IX_ADDR_STROBE];
  assign cs_n_s = synced[SPBA_IX_CS];
  assign a3_s = synced[SPBA_IX_A3];
  assign wait_n_s = synced[SPBA_IX_WAIT];
  assign burst_last_n_s = synced[SPBA_IX_BURST_LAST];
  assign selected = !addr_strobe_n_s && !cs_n_s; // [RULE2]

  // There is no ready output: the processor's own wait states and its
  // burst last alone set how long each access lasts. [RULE9]
  // The region is taken to be byte wide and single access, so one burst
  // last closes every access. [RULE8]
  always_comb begin
    state_d = state_q;
    sel_serial_d = sel_serial_q;
    is_write_d = is_write_q;
    case (state_q)
      SPBA_IDLE: begin
        if (selected) begin
          state_d = SPBA_HOLD1;
          sel_serial_d = a3_s; // [RULE1]
          is_write_d = transfer_direction_i;
        end
      end
      // Holding off the command gives the peripherals their address setup
      // and recovery time between back-to-back accesses.
      SPBA_HOLD1: begin
        state_d = SPBA_HOLD2; // [RULE7] [RULE12]
      end
      SPBA_HOLD2: begin
        state_d = SPBA_HOLD3; // [RULE12]
      end
      SPBA_HOLD3: begin
        state_d = is_write_q ? SPBA_WRITE : SPBA_READ; // [RULE12]
      end
      SPBA_READ: begin
        // The read strobe rises on leaving, so the processor's turnaround
        // states give the peripheral time to float its data. [RULE10] [RULE11]
        if (!burst_last_n_s) begin
          state_d = SPBA_IDLE; // [RULE13]
        end
      end
      SPBA_WRITE: begin
        if (!burst_last_n_s) begin
          state_d = SPBA_IDLE; // [RULE14]
        end
      end
      default: begin
        state_d = SPBA_IDLE;
      end
    endcase
  end

  // Strobes are decoded from the next state so they change with the state register.
  always_comb begin
    strobes_d = SPBA_STROBES_IDLE;
    case (state_d)
      SPBA_IDLE: begin
        strobes_d = SPBA_STROBES_IDLE; // [RULE15]
      end
      SPBA_HOLD1: begin
        strobes_d.serial_chip_enable_n = !sel_serial_d; // [RULE1] [RULE3]
        strobes_d.timer_chip_enable_n = sel_serial_d; // [RULE1] [RULE3]
        strobes_d.data_enable_n = 1'b0; // [RULE3] [RULE12]
      end
      SPBA_HOLD2: begin
        strobes_d.serial_chip_enable_n = !sel_serial_d; // [RULE1] [RULE3]
        strobes_d.timer_chip_enable_n = sel_serial_d; // [RULE1] [RULE3]
        strobes_d.data_enable_n = 1'b0; // [RULE3] [RULE12]
      end
      SPBA_HOLD3: begin
        strobes_d.serial_chip_enable_n = !sel_serial_d; // [RULE1] [RULE3]
        strobes_d.timer_chip_enable_n = sel_serial_d; // [RULE1] [RULE3]
        strobes_d.data_enable_n = 1'b0; // [RULE3] [RULE12]
      end
      SPBA_READ: begin
        strobes_d.serial_chip_enable_n = !sel_serial_d; // [RULE1] [RULE3]
        strobes_d.timer_chip_enable_n = sel_serial_d; // [RULE1] [RULE3]
        strobes_d.data_enable_n = 1'b0; // [RULE3]
        strobes_d.read_strobe_n = 1'b0; // [RULE13]
      end
      SPBA_WRITE: begin
        strobes_d.serial_chip_enable_n = !sel_serial_d; // [RULE1] [RULE3]
        strobes_d.timer_chip_enable_n = sel_serial_d; // [RULE1] [RULE3]
        strobes_d.data_enable_n = 1'b0; // [RULE3]
        strobes_d.write_strobe_n = wait_n_s; // [RULE6] [RULE14]
      end
      default: begin
        strobes_d = SPBA_STROBES_IDLE;
      end
    endcase
  end

  always_comb begin
    xcvr_en_n_d = cs_n_s || strobes_d.data_enable_n; // [RULE4]
    // The direction path only adds the output register so outputs stay flopped.
    xcvr_dir_d = transfer_direction_i; // [RULE5]
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SPBA_IDLE; // [RULE15]
      sel_serial_q <= 1'b0;
      is_write_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_serial_q <= sel_serial_d;
      is_write_q <= is_write_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobes_q <= SPBA_STROBES_IDLE; // [RULE15]
    end else begin
      strobes_q <= strobes_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xcvr_en_n_q <= 1'b1;
      xcvr_dir_q <= 1'b0;
    end else begin
      xcvr_en_n_q <= xcvr_en_n_d;
      xcvr_dir_q <= xcvr_dir_d;
    end
  end

  assign serial_chip_enable_n_o = strobes_q.serial_chip_enable_n;
  assign timer_chip_enable_n_o = strobes_q.timer_chip_enable_n;
  assign read_strobe_n_o = strobes_q.read_strobe_n;
  assign write_strobe_n_o = strobes_q.write_strobe_n;
  assign data_enable_n_o = strobes_q.data_enable_n;
  assign transceiver_enable_n_o = xcvr_en_n_q;
  assign transceiver_dir_o = xcvr_dir_q;

endmodule // spba_adapter

// [core/spba_pkg.sv]
// Package for the slow peripheral bus adapter: states, output bundle, constants.
// Assumes a single bus clock shared with the processor local bus.
package spba_pkg;

  typedef enum logic [2:0] {
    SPBA_IDLE,
    SPBA_HOLD1,
    SPBA_HOLD2,
    SPBA_HOLD3,
    SPBA_READ,
    SPBA_WRITE
  } spba_state_t;

  // Strobes toward the peripherals, all active low.
  typedef struct packed {
    logic serial_chip_enable_n;
    logic timer_chip_enable_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic data_enable_n;
  } spba_strobes_t;

  localparam spba_strobes_t SPBA_STROBES_IDLE = 5'h1f;
  localparam int SPBA_SYNC_STAGES = 2;
  localparam int SPBA_SYNC_W = 5;
  // Bit positions within the synchronised input vector.
  localparam int SPBA_IX_ADDR_STROBE = 0;
  localparam int SPBA_IX_CS = 1;
  localparam int SPBA_IX_A3 = 2;
  localparam int SPBA_IX_WAIT = 3;
  localparam int SPBA_IX_BURST_LAST = 4;

endpackage

// [core/spba_sync.sv]
// Two-flop synchroniser bank for pin inputs of the adapter.
// Assumes inputs may change asynchronously to the bus clock.
`timescale 1ns/1ps
module spba_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // spba_sync

// [dv/spba_adapter_asserts.sv]
// Port checker for the adapter.
// Assumes two synchroniser flops, so pin causes lead outputs by three edges, the transfer direction by one.
`timescale 1ns/1ps
module spba_adapter_asserts (
  // Watched ports
  input wire logic sys_clk_i, rst_n_i, address_strobe_n_i, burst_last_n_i, wait_n_i,
  input wire logic transfer_direction_i, addr_bit3_i, chip_select_n_i, serial_chip_enable_n_o,
  input wire logic timer_chip_enable_n_o, read_strobe_n_o, write_strobe_n_o, data_enable_n_o,
  input wire logic transceiver_enable_n_o, transceiver_dir_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ce_n = serial_chip_enable_n_o & timer_chip_enable_n_o;
  property p_hold; $fell(ce_n) |-> (read_strobe_n_o && write_strobe_n_o) [*3]; endproperty
  a_hold: assert property (p_hold) else $error("strobe in hold");
  property p_pick; $fell(ce_n) |-> serial_chip_enable_n_o == !$past(addr_bit3_i, 3); endproperty
  a_pick: assert property (p_pick) else $error("wrong chip");
  property p_qual; $fell(ce_n) |-> $past(!address_strobe_n_i && !chip_select_n_i, 3); endproperty
  a_qual: assert property (p_qual) else $error("bad select");
  property p_den; data_enable_n_o == ce_n; endproperty
  a_den: assert property (p_den) else $error("data enable");
  property p_xcvr;
    transceiver_enable_n_o == ($past(chip_select_n_i, 3) | data_enable_n_o);
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("xcvr enable");
  property p_dir; transceiver_dir_o == $past(transfer_direction_i); endproperty
  a_dir: assert property (p_dir) else $error("xcvr dir");
  property p_wr; !write_strobe_n_o |-> !$past(wait_n_i, 3) && read_strobe_n_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  property p_rd;
    !read_strobe_n_o |=> read_strobe_n_o == !$past(burst_last_n_i, 3) && ce_n == read_strobe_n_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  cover property (!read_strobe_n_o);
  cover property (!write_strobe_n_o && !timer_chip_enable_n_o);
  cover property ($fell(serial_chip_enable_n_o));
endmodule // spba_adapter_asserts

// [dv/spba_host.sv]
// Host bus model: one non-burst byte access per go pulse.
// Assumes go is a one-clock pulse given while busy is low.
`timescale 1ns/1ps
module spba_host #(
  parameter int TURNAROUND_WAIT_STATES = 2
) (
  // Clock, reset and request
  input wire logic sys_clk_i, rst_n_i, go, wr, a3, cs,
  input wire logic [3:0] w,
  // Processor pins, named as the adapter inputs they feed, and the busy flag
  output logic address_strobe_n_i, burst_last_n_i, wait_n_i, transfer_direction_i,
  output logic addr_bit3_i, chip_select_n_i, busy
);
  logic [4:0] n_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) n_q <= 5'h1f;
    else if (go) n_q <= 5'h0;
    else if (n_q != 5'h1f) n_q <= n_q + 5'h1;
  // Turnaround states leave data released long enough to float.
  assign busy = n_q <= w + TURNAROUND_WAIT_STATES;
  assign address_strobe_n_i = n_q != 5'h0;
  // Single byte access, so burst last marks the only data cycle.
  assign burst_last_n_i = n_q != {1'b0, w};
  // Wait states alone set the cycle length.
  assign wait_n_i = !(n_q != 5'h0 && n_q + 5'h2 <= {1'b0, w});
  assign chip_select_n_i = !(cs && n_q <= {1'b0, w});
  assign transfer_direction_i = wr;
  // Address goes stale after the access, so an old value cannot pass.
  assign addr_bit3_i = busy ? a3 : !a3;
endmodule // spba_host

// [dv/slow_peripheral_bus_adapter_test.sv]
// Bench for the adapter: a host model runs accesses, tasks judge the strobes.
// Assumes the checker is bound to the adapter.
`timescale 1ns/1ps
module slow_peripheral_bus_adapter_test;
  logic sys_clk_i = '0, rst_n_i = '0, go = '0, wr = '0, a3 = '0, cs = '1, busy;
  logic [3:0] w = 4'h6;
  logic address_strobe_n_i, burst_last_n_i, wait_n_i, transfer_direction_i, addr_bit3_i;
  logic chip_select_n_i, serial_chip_enable_n_o, timer_chip_enable_n_o, read_strobe_n_o;
  logic write_strobe_n_o, data_enable_n_o, transceiver_enable_n_o, transceiver_dir_o;
  logic [7:0] hold, sc, tc, rc, wc, xc, i;
  int errors = 0, checked = 0;
  spba_adapter dut (.*);
  spba_host host (.*);
  always #10 sys_clk_i = ~sys_clk_i;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Counts are taken until both the host and the adapter are idle again.
  task xfer(input logic d, input logic s, input logic [3:0] n);
    {hold, sc, tc, rc, wc, xc, i} = '0;
    @(posedge sys_clk_i);
    wr <= d;
    a3 <= s;
    w <= n;
    go <= '1;
    @(posedge sys_clk_i) go <= '0;
    do begin
      @(negedge sys_clk_i);
      i++;
      sc += !serial_chip_enable_n_o;
      tc += !timer_chip_enable_n_o;
      rc += !read_strobe_n_o;
      wc += !write_strobe_n_o;
      xc += !transceiver_enable_n_o;
      hold += (rc + wc == 8'h0) && !(serial_chip_enable_n_o && timer_chip_enable_n_o);
    end while ((busy || !data_enable_n_o) && i < 8'h28);
    chk(busy, 1'b0);
  endtask
  task t_read;
    xfer(1'b0, 1'b1, 4'h6);
    chk(hold, 8'h3);
    chk({sc, tc}, 16'h0600);
    chk({rc, wc}, 16'h0300);
    chk(xc, 16'h6);
    $display("read done");
  endtask
  task t_write;
    xfer(1'b1, 1'b0, 4'ha);
    chk(hold, 8'h3);
    chk({sc, tc}, 16'h000a);
    chk({rc, wc}, 16'h0006);
    chk(xc, 16'ha);
    chk(transceiver_dir_o, 1'b1);
    $display("write done");
  endtask
  task t_nocs;
    @(posedge sys_clk_i) cs <= '0;
    xfer(1'b0, 1'b1, 4'h6);
    chk({sc, tc}, 16'h0);
    chk(xc, 16'h0);
    @(posedge sys_clk_i) cs <= '1;
    $display("nocs done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= '1;
    @(negedge sys_clk_i);
    chk({serial_chip_enable_n_o, timer_chip_enable_n_o, read_strobe_n_o, write_strobe_n_o,
      data_enable_n_o, transceiver_enable_n_o, transceiver_dir_o}, 8'h7e);
    t_read;
    t_write;
    t_nocs;
    summarize;
  end
  initial begin
    #8000;
    errors++;
    summarize;
  end
endmodule // slow_peripheral_bus_adapter_test
bind spba_adapter spba_adapter_asserts chk_u (.*);
